// ==== verilog/eesq_sequencer.sv ====
// eesq_sequencer: single-byte serial eeprom access sequencer, three-wire and two-wire
// assumes: eeprom on scl/sda/select; link clock free running; software on plain ports
//
// Operation
// R1 - select line rises to begin a three-wire transaction, falls to end, even on busy
// R2 - commands: 00h addressed write, 80h current read, C0h addressed read
// R3 - after command, clock in one status byte sending ones; 00h means ready
// R4 - busy status sets busy flag; no address or data moves; software retries
// R5 - receive shifts out ones, stores the byte before reporting completion
// R6 - memory returns byte at its word address and increments it per byte
// R7 - every transaction carries exactly one data byte
// R8 - two-wire start: data falls while serial clock is high
// R9 - first two-wire byte: target address in bits 7..1, bit 0 direction
// R10 - write direction sends word address byte, then one data byte
// R11 - two-wire stop: data rises while serial clock is high
// R12 - addressed read: write word address, repeated start, read address, receive
// R13 - host never drives acknowledge on the final received byte
// R14 - missing acknowledge on a sent byte stops at once and sets error flag
// R15 - start and stop built from clock level, data release and trigger controls
// R16 - each two-wire byte completes on rising ninth clock, clock left high
// R17 - serial clock low at two-wire start: set busy flag, do not start
// R18 - flags stay set until software clears; new transaction clears busy
`timescale 1ns/1ns
module eesq_sequencer (
  // clocks and reset
  input wire logic mclk_in,
  input wire logic link_clk_in,
  input wire logic resetn_in,
  // transaction request
  input wire logic start_in,
  input wire logic two_wire_in,
  input wire logic write_to_read_switch_flag_in,
  input wire logic [7:0] command_byte_store_in,
  input wire logic [7:0] word_address_store_in,
  input wire logic [7:0] transmit_byte_store_in,
  input wire logic [7:0] target_address_store_in,
  // flag clears
  input wire logic clear_busy_in,
  input wire logic clear_error_in,
  // status
  output logic running_out,
  output logic transfer_done_flag_out,
  output logic memory_busy_flag_out,
  output logic ack_error_flag_out,
  output logic [7:0] received_byte_store_out,
  // serial pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic memory_select_line_out
);

  eesq_pkg::eesq_link_t r_ff;
  eesq_pkg::eesq_link_t nxt_r;
  eesq_pkg::eesq_req_t req;
  logic req_tgl;
  logic req_s;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic two;
  logic last_bit;
  logic nack;
  logic [7:0] rxb;

  // ---------------------------------------------------------------
  // system-clock front end
  // ---------------------------------------------------------------
  eesq_front u_front (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .start_in(start_in),
    .req_in({two_wire_in, write_to_read_switch_flag_in, command_byte_store_in,
             word_address_store_in, transmit_byte_store_in, target_address_store_in}),
    .clear_busy_in(clear_busy_in),
    .clear_error_in(clear_error_in),
    .ack_tgl_in(r_ff.ack_tgl),
    .res_in(r_ff.res),
    .req_tgl_out(req_tgl),
    .req_out(req),
    .running_out(running_out),
    .done_out(transfer_done_flag_out),
    .memory_busy_flag_out(memory_busy_flag_out),
    .ack_error_flag_out(ack_error_flag_out),
    .rx_byte_out(received_byte_store_out)
  );

  eesq_sync #(.W(3)) u_link_sync (
    .clk_in(link_clk_in),
    .resetn_in(resetn_in),
    .d_in({req_tgl, scl_in, sda_in}),
    .q_out({req_s, scl_s, sda_s})
  );

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  function automatic logic is_kind(input logic [7:0] cmd, input logic [7:0] kind);
    is_kind = (cmd & eesq_pkg::CMD_KIND_MASK) == kind;
  endfunction

  // ---------------------------------------------------------------
  // link engine
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    tick = r_ff.cnt == eesq_pkg::QTR_LAST;
    two = req.two_wire;
    last_bit = r_ff.bit_no == (two ? eesq_pkg::LAST_BIT_2W : eesq_pkg::LAST_BIT_3W);
    rxb = two ? r_ff.shift : {r_ff.shift[6:0], sda_s};
    nack = two && sda_s;
    nxt_r.cnt = tick ? 4'h0 : r_ff.cnt + 4'h1;
    if (tick) begin
      nxt_r.q = r_ff.q + 2'h1;
    end
    case (r_ff.st)
      eesq_pkg::ST_IDLE: begin
        nxt_r.scl_oe = 1'b0;
        nxt_r.sda_oe = 1'b0;
        if (req_s != r_ff.req_seen && tick) begin
          nxt_r.req_seen = req_s;
          nxt_r.res.mem_busy = 1'b0; // [R18]
          nxt_r.res.ack_err = 1'b0;
          nxt_r.res.rx_valid = 1'b0;
          nxt_r.addr_rd = req.target_address[eesq_pkg::DIR_BIT]; // [R9]
          nxt_r.q = 2'h0;
          nxt_r.st = two ? eesq_pkg::ST_CHECK : eesq_pkg::ST_SELECT;
        end
      end
      eesq_pkg::ST_CHECK: begin
        if (tick) begin
          nxt_r.q = 2'h0;
          if (!scl_s) begin
            nxt_r.res.mem_busy = 1'b1; // [R17]
            nxt_r.st = eesq_pkg::ST_REPORT;
          end else begin
            nxt_r.st = eesq_pkg::ST_START;
          end
        end
      end
      eesq_pkg::ST_SELECT: begin
        if (tick) begin
          nxt_r.sel = 1'b1; // [R1]
          nxt_r.step = eesq_pkg::STEP_CMD;
          nxt_r.shift = req.command_byte; // [R2]
          nxt_r.bit_no = 4'h0;
          nxt_r.q = 2'h0;
          nxt_r.st = eesq_pkg::ST_BYTE;
        end
      end
      eesq_pkg::ST_START: begin
        if (tick) begin
          case (r_ff.q)
            2'h0: begin
              nxt_r.scl_oe = 1'b1;
              nxt_r.sda_oe = 1'b0; // [R15]
            end
            2'h1: begin
              nxt_r.scl_oe = 1'b0; // [R15]
            end
            2'h2: begin
              nxt_r.sda_oe = 1'b1; // [R8]
            end
            default: begin
              nxt_r.step = eesq_pkg::STEP_ADDR;
              nxt_r.shift = {req.target_address[7:1], r_ff.addr_rd}; // [R9]
              nxt_r.bit_no = 4'h0;
              nxt_r.st = eesq_pkg::ST_BYTE;
            end
          endcase
        end
      end
      eesq_pkg::ST_BYTE: begin
        if (tick) begin
          case (r_ff.q)
            2'h0: begin
              nxt_r.scl_oe = 1'b1;
            end
            2'h1: begin
              if (r_ff.bit_no == eesq_pkg::LAST_BIT_2W) begin
                nxt_r.sda_oe = eesq_pkg::ACK_ENABLE && r_ff.step == eesq_pkg::STEP_RX; // [R13]
              end else begin
                nxt_r.sda_oe = ~r_ff.shift[7]; // [R3] [R5]
              end
            end
            2'h2: begin
              nxt_r.scl_oe = 1'b0;
            end
            default: begin
              if (r_ff.bit_no != eesq_pkg::LAST_BIT_2W) begin
                nxt_r.shift = {r_ff.shift[6:0], sda_s};
              end
              nxt_r.bit_no = r_ff.bit_no + 4'h1;
              nxt_r.q = 2'h0;
              if (last_bit) begin
                // byte done, clock left high [R16]
                nxt_r.q = 2'h0;
                nxt_r.bit_no = 4'h0;
                case (r_ff.step)
                  eesq_pkg::STEP_CMD: begin
                    nxt_r.step = eesq_pkg::STEP_STAT;
                    nxt_r.shift = eesq_pkg::FILL_ONES; // [R3]
                  end
                  eesq_pkg::STEP_STAT: begin
                    if (rxb != eesq_pkg::STATUS_READY) begin
                      nxt_r.res.mem_busy = 1'b1; // [R4]
                      nxt_r.st = eesq_pkg::ST_DESEL;
                    end else if (is_kind(req.command_byte, eesq_pkg::CMD_CUR_READ)) begin
                      nxt_r.step = eesq_pkg::STEP_RX; // [R2]
                      nxt_r.shift = eesq_pkg::FILL_ONES;
                    end else begin
                      nxt_r.step = eesq_pkg::STEP_WA;
                      nxt_r.shift = req.word_address;
                    end
                  end
                  eesq_pkg::STEP_ADDR: begin
                    if (nack) begin
                      nxt_r.res.ack_err = 1'b1; // [R14]
                      nxt_r.st = eesq_pkg::ST_STOP;
                    end else if (r_ff.addr_rd) begin
                      nxt_r.step = eesq_pkg::STEP_RX;
                      nxt_r.shift = eesq_pkg::FILL_ONES;
                    end else begin
                      nxt_r.step = eesq_pkg::STEP_WA; // [R10]
                      nxt_r.shift = req.word_address;
                    end
                  end
                  eesq_pkg::STEP_WA: begin
                    if (nack) begin
                      nxt_r.res.ack_err = 1'b1; // [R14]
                      nxt_r.st = eesq_pkg::ST_STOP;
                    end else if (two && req.write_to_read_switch_flag) begin
                      nxt_r.addr_rd = 1'b1; // [R12]
                      nxt_r.st = eesq_pkg::ST_START;
                    end else if (!two && is_kind(req.command_byte, eesq_pkg::CMD_RAND_READ)) begin
                      nxt_r.step = eesq_pkg::STEP_RX; // [R2]
                      nxt_r.shift = eesq_pkg::FILL_ONES;
                    end else begin
                      nxt_r.step = eesq_pkg::STEP_TX; // [R10] [R7]
                      nxt_r.shift = req.transmit_byte;
                    end
                  end
                  eesq_pkg::STEP_TX: begin
                    nxt_r.res.ack_err = nack; // [R14]
                    nxt_r.st = two ? eesq_pkg::ST_STOP : eesq_pkg::ST_DESEL; // [R7]
                  end
                  default: begin
                    nxt_r.res.rx_byte = rxb; // [R5]
                    nxt_r.res.rx_valid = 1'b1;
                    nxt_r.st = two ? eesq_pkg::ST_STOP : eesq_pkg::ST_DESEL; // [R7]
                  end
                endcase
              end
            end
          endcase
        end
      end
      eesq_pkg::ST_STOP: begin
        if (tick) begin
          case (r_ff.q)
            2'h0: begin
              nxt_r.scl_oe = 1'b1;
            end
            2'h1: begin
              nxt_r.sda_oe = 1'b1; // [R15]
            end
            2'h2: begin
              nxt_r.scl_oe = 1'b0; // [R15]
            end
            default: begin
              nxt_r.sda_oe = 1'b0; // [R11]
              nxt_r.st = eesq_pkg::ST_REPORT;
            end
          endcase
        end
      end
      eesq_pkg::ST_DESEL: begin
        if (tick) begin
          nxt_r.sel = 1'b0; // [R1]
          nxt_r.sda_oe = 1'b0;
          nxt_r.st = eesq_pkg::ST_REPORT;
        end
      end
      default: begin
        nxt_r.ack_tgl = ~r_ff.ack_tgl;
        nxt_r.st = eesq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_ff <= eesq_pkg::LINK_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign scl_out = r_ff.line_lvl;
  assign scl_oe_out = r_ff.scl_oe;
  assign sda_out = r_ff.line_lvl;
  assign sda_oe_out = r_ff.sda_oe;
  assign memory_select_line_out = r_ff.sel;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_SEL_IDLE_LOW: assert property (@(posedge link_clk_in) disable iff (!resetn_in) // [R1]
    (r_ff.st == eesq_pkg::ST_IDLE) |-> !r_ff.sel)
    else $error("select line high while idle");

  AST_STATUS_ONES: assert property (@(posedge link_clk_in) disable iff (!resetn_in) // [R3]
    (r_ff.st == eesq_pkg::ST_BYTE && r_ff.step == eesq_pkg::STEP_STAT && r_ff.q == 2'h2)
    |-> !r_ff.sda_oe)
    else $error("data driven low while reading status");

  AST_BUSY_ABANDON: assert property (@(posedge link_clk_in) disable iff (!resetn_in) // [R4]
    (r_ff.st == eesq_pkg::ST_BYTE && r_ff.step == eesq_pkg::STEP_STAT && r_ff.q == 2'h3
     && tick && last_bit && rxb != eesq_pkg::STATUS_READY)
    |=> r_ff.st == eesq_pkg::ST_DESEL && r_ff.res.mem_busy)
    else $error("address or data moved after a busy status");

  AST_NO_FINAL_ACK: assert property (@(posedge link_clk_in) disable iff (!resetn_in) // [R13]
    (r_ff.st == eesq_pkg::ST_BYTE && r_ff.step == eesq_pkg::STEP_RX
     && r_ff.bit_no == eesq_pkg::LAST_BIT_2W && r_ff.q == 2'h2) |-> !r_ff.sda_oe)
    else $error("host drove acknowledge on the final received byte");

endmodule

// ==== verilog/eesq_pkg.sv ====
// eesq_pkg: constants, carriers and state records of the serial eeprom sequencer
// assumes: shared by the system-clock front end and the link-clock engine
package eesq_pkg;

  // ---------------------------------------------------------------
  // command and status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RAND_WRITE = 8'h00;
  localparam logic [7:0] CMD_CUR_READ = 8'h80;
  localparam logic [7:0] CMD_RAND_READ = 8'hC0;
  localparam logic [7:0] CMD_KIND_MASK = 8'hC0;
  localparam logic [7:0] STATUS_READY = 8'h00;
  localparam logic [7:0] FILL_ONES = 8'hFF;
  localparam int DIR_BIT = 0;
  localparam logic ACK_ENABLE = 1'b0;

  // ---------------------------------------------------------------
  // serial clock timing, link clock cycles per quarter bit
  // ---------------------------------------------------------------
  localparam int LINK_PERIOD_NS = 6;
  localparam int SCL_QTR_NS = 48;
  localparam int QTR_CYC = (SCL_QTR_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);
  localparam logic [3:0] LAST_BIT_3W = 4'h7;
  localparam logic [3:0] LAST_BIT_2W = 4'h8;

  // ---------------------------------------------------------------
  // states and byte steps
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_SELECT = 3'h2,
    ST_START = 3'h3,
    ST_BYTE = 3'h4,
    ST_STOP = 3'h5,
    ST_DESEL = 3'h6,
    ST_REPORT = 3'h7
  } eesq_state_t;

  typedef enum logic [2:0] {
    STEP_CMD = 3'h0,
    STEP_STAT = 3'h1,
    STEP_WA = 3'h2,
    STEP_TX = 3'h3,
    STEP_RX = 3'h4,
    STEP_ADDR = 3'h5
  } eesq_step_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic two_wire;
    logic write_to_read_switch_flag;
    logic [7:0] command_byte;
    logic [7:0] word_address;
    logic [7:0] transmit_byte;
    logic [7:0] target_address;
  } eesq_req_t;

  typedef struct packed {
    logic mem_busy;
    logic ack_err;
    logic rx_valid;
    logic [7:0] rx_byte;
  } eesq_res_t;

  typedef struct packed {
    eesq_state_t st;
    eesq_step_t step;
    logic req_seen;
    logic ack_tgl;
    eesq_res_t res;
    logic [3:0] cnt;
    logic [1:0] q;
    logic [3:0] bit_no;
    logic [7:0] shift;
    logic addr_rd;
    logic scl_oe;
    logic sda_oe;
    logic sel;
    logic line_lvl;
  } eesq_link_t;

  typedef struct packed {
    logic req_tgl;
    eesq_req_t req;
    logic running;
    logic done;
    logic mbusy;
    logic aerr;
    logic [7:0] rx_byte;
    logic ack_seen;
  } eesq_front_t;

  localparam eesq_link_t LINK_RESET = '0;
  localparam eesq_front_t FRONT_RESET = '0;

endpackage

// ==== verilog/eesq_sync.sv ====
// eesq_sync: two-flop synchroniser for levels and toggles
// assumes: inputs come from another clock domain or from pins
`timescale 1ns/1ns
module eesq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } eesq_sync_t;

  eesq_sync_t r_ff;
  eesq_sync_t nxt_r;

  always_comb begin
    nxt_r.s1 = d_in;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q_out = r_ff.s2;

endmodule

// ==== verilog/eesq_front.sv ====
// eesq_front: system-clock side, request handshake and software flags
// assumes: link engine answers each request toggle with one result toggle
`timescale 1ns/1ns
module eesq_front (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // software side
  input wire logic start_in,
  input wire eesq_pkg::eesq_req_t req_in,
  input wire logic clear_busy_in,
  input wire logic clear_error_in,
  // link side
  input wire logic ack_tgl_in,
  input wire eesq_pkg::eesq_res_t res_in,
  output logic req_tgl_out,
  output eesq_pkg::eesq_req_t req_out,
  // status
  output logic running_out,
  output logic done_out,
  output logic memory_busy_flag_out,
  output logic ack_error_flag_out,
  output logic [7:0] rx_byte_out
);

  eesq_pkg::eesq_front_t r_ff;
  eesq_pkg::eesq_front_t nxt_r;
  logic ack_s;
  logic accept;
  logic ack_edge;

  eesq_sync #(.W(1)) u_ack_sync (
    .clk_in(mclk_in),
    .resetn_in(resetn_in),
    .d_in(ack_tgl_in),
    .q_out(ack_s)
  );

  // ---------------------------------------------------------------
  // handshake and flags
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    accept = start_in && !r_ff.running;
    ack_edge = ack_s != r_ff.ack_seen;
    nxt_r.ack_seen = ack_s;
    if (accept) begin
      nxt_r.req = req_in;
      nxt_r.req_tgl = ~r_ff.req_tgl;
      nxt_r.running = 1'b1;
    end
    if (clear_busy_in || accept) begin
      nxt_r.mbusy = 1'b0; // [R18]
    end
    if (clear_error_in) begin
      nxt_r.aerr = 1'b0; // [R18]
    end
    if (ack_edge) begin
      nxt_r.running = 1'b0;
      nxt_r.done = 1'b1;
      if (res_in.mem_busy) begin
        nxt_r.mbusy = 1'b1; // [R4] [R17]
      end
      if (res_in.ack_err) begin
        nxt_r.aerr = 1'b1; // [R14]
      end
      if (res_in.rx_valid) begin
        nxt_r.rx_byte = res_in.rx_byte; // [R5]
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_ff <= eesq_pkg::FRONT_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign req_tgl_out = r_ff.req_tgl;
  assign req_out = r_ff.req;
  assign running_out = r_ff.running;
  assign done_out = r_ff.done;
  assign memory_busy_flag_out = r_ff.mbusy;
  assign ack_error_flag_out = r_ff.aerr;
  assign rx_byte_out = r_ff.rx_byte;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_FLAG_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R18]
    (r_ff.aerr && !clear_error_in) |=> r_ff.aerr)
    else $error("error flag dropped without a clear");

  AST_BUSY_CLEARED_AT_START: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R18]
    (accept && !ack_edge) |=> !r_ff.mbusy && r_ff.running)
    else $error("busy flag not cleared when a transaction began");

endmodule

// ==== dv/eesq_mem_model.sv ====
// eesq_mem_model: behavioural serial eeprom, three-wire and two-wire
// assumes: the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ns
module eesq_mem_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // serial lines
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sel_in,
  // faults ordered by the bench
  input wire logic busy_in,
  input wire logic [2:0] nack_at_in,
  input wire logic hold_scl_in,
  // line pulls
  output logic sda_oe_out,
  output logic scl_oe_out
);
  logic [7:0] mem [256];
  logic [7:0] wa = 8'h00;
  logic [7:0] sh, cmd, ob;
  logic rd = 1'b0;
  logic ackd = 1'b0;
  logic w3 = 1'b0;
  logic host_ack;
  int k = 0;
  int nbit = 0;
  int last_k = 0;
  int starts = 0;
  int stops = 0;
  assign scl_oe_out = hold_scl_in;
  initial begin
    sda_oe_out = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 7 + 3);
  end
  // ----------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------
  function automatic logic is_out();
    if (sel_in)
      return k == 1 || (cmd == 8'h80 && k == 2) || (cmd == 8'hC0 && k == 3);
    return rd && k == 1;
  endfunction
  always @(sel_in) begin
    if (!sel_in)
      last_k = k;
    else
      w3 = 1'b1;
    k = 0;
    nbit = 0;
    sda_oe_out = 1'b0;
  end
  always @(sda_in) begin
    if (scl_in === 1'b1 && sel_in === 1'b0) begin
      if (sda_in === 1'b0) begin
        starts++;
        w3 = 1'b0;
        k = 0;
        nbit = 0;
      end else if (!w3) begin
        stops++;
        last_k = k;
      end
    end
  end
  always @(posedge scl_in) begin
    if (nbit < 8)
      sh = {sh[6:0], sda_in};
    else
      host_ack = sda_in;
    nbit++;
    if (nbit == (sel_in ? 8 : 9)) begin
      if (is_out() && !(sel_in && k == 1))
        wa++;
      else if (!is_out() && sel_in) begin
        if (k == 0)
          cmd = sh;
        if (k == 2)
          wa = sh;
        if (k == 3)
          mem[wa] = sh;
      end else if (!is_out()) begin
        if (k == 0)
          rd = ackd && sh[0];
        if (k == 1 && ackd)
          wa = sh;
        if (k == 2 && ackd)
          mem[wa] = sh;
      end
      k++;
      nbit = 0;
    end
  end
  always @(negedge scl_in) begin
    ackd = !sel_in && nbit == 8 && !is_out() && nack_at_in != 3'(k)
      && (k != 0 || sh[7:1] == DEV_ADDR);
    ob = (sel_in && k == 1) ? (busy_in ? 8'hA5 : 8'h00) : mem[wa];
    if (is_out() && nbit < 8)
      sda_oe_out = !ob[7 - nbit];
    else
      sda_oe_out = ackd;
  end
endmodule

// ==== dv/tb.sv ====
// tb: serial eeprom sequencer against a behavioural memory and a reference array
// assumes: eesq_mem_model shares the pulled-up open-drain lines
`timescale 1ns/1ns
module tb;
  localparam logic [6:0] DEV = 7'h50;
  logic mclk_in = 1'b0;
  logic lclk = 1'b0;
  logic resetn_in = 1'b0;
  logic start = 1'b0, two = 1'b0, sw = 1'b0, clr_b = 1'b0, clr_e = 1'b0;
  logic busy = 1'b0, hold = 1'b0;
  logic [2:0] nack_at = 3'h7;
  logic [7:0] cmd = 8'h00, wa = 8'h00, tx = 8'h00, tgt = 8'h00, rx;
  logic run_o, done, mbusy, aerr, scl_oe, sda_oe, sel, m_sda, m_scl;
  wire logic scl = !(scl_oe || m_scl);
  wire logic sda = !(sda_oe || m_sda);
  int errors = 0;
  int comparisons = 0;
  int ref_mem [256];
  int s0, p0;
  logic [31:0] seed = 32'h2C469FC4;
  eesq_sequencer dut (
    .mclk_in(mclk_in), .link_clk_in(lclk), .resetn_in(resetn_in), .start_in(start),
    .two_wire_in(two), .write_to_read_switch_flag_in(sw), .command_byte_store_in(cmd),
    .word_address_store_in(wa), .transmit_byte_store_in(tx), .target_address_store_in(tgt),
    .clear_busy_in(clr_b), .clear_error_in(clr_e), .running_out(run_o),
    .transfer_done_flag_out(done), .memory_busy_flag_out(mbusy), .ack_error_flag_out(aerr),
    .received_byte_store_out(rx), .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .memory_select_line_out(sel));
  eesq_mem_model #(.DEV_ADDR(DEV)) mdl (
    .scl_in(scl), .sda_in(sda), .sel_in(sel), .busy_in(busy), .nack_at_in(nack_at),
    .hold_scl_in(hold), .sda_oe_out(m_sda), .scl_oe_out(m_scl));
  initial forever #4 mclk_in = !mclk_in;
  initial begin
    #1;
    forever #3 lclk = !lclk;
  end
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t %s: %h not %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t %s: %b not %b", $time, m, got, exp);
    end
  endtask
  task automatic frames(input int s, input int p);
    chk8(8'(mdl.starts - s0), 8'(s), "starts");
    chk8(8'(mdl.stops - p0), 8'(p), "stops");
    s0 = mdl.starts;
    p0 = mdl.stops;
  endtask
  task automatic run(input logic w2, input logic s, input logic [7:0] c, a, d, t);
    int n = 0;
    @(posedge mclk_in);
    two <= w2;
    sw <= s;
    cmd <= c;
    wa <= a;
    tx <= d;
    tgt <= t;
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    @(negedge mclk_in);
    chk1(run_o, 1'b1, "request taken");
    do begin
      @(negedge mclk_in);
      n++;
    end while (done !== 1'b1 && n < 5000);
    chk1(done, 1'b1, "completion");
    chk1(run_o, 1'b0, "running");
  endtask
  task automatic clear(input logic b, input logic e);
    @(posedge mclk_in);
    clr_b <= b;
    clr_e <= e;
    @(posedge mclk_in);
    clr_b <= 1'b0;
    clr_e <= 1'b0;
    @(negedge mclk_in);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    logic [7:0] a, d;
    for (int i = 0; i < 256; i++)
      ref_mem[i] = (i * 7 + 3) % 256;
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    s0 = mdl.starts;
    p0 = mdl.stops;
    for (int i = 0; i < 4; i++) begin
      a = 8'(xs());
      d = 8'(xs());
      run(1'b0, 1'b0, 8'h00, a, d, 8'h00);
      ref_mem[a] = d;
      chk8(mdl.mem[a], d, "3w write");
      chk8(8'(mdl.last_k), 8'h04, "3w write bytes");
      run(1'b0, 1'b0, 8'hC0, a, 8'h00, 8'h00);
      chk8(rx, d, "3w read");
      run(1'b0, 1'b0, 8'h80, 8'h00, 8'h00, 8'h00);
      chk8(rx, 8'(ref_mem[8'(a + 1)]), "3w current read");
      chk1(sel, 1'b0, "select");
    end
    $display("test three-wire done");
    busy = 1'b1;
    run(1'b0, 1'b0, 8'h00, 8'h10, 8'h3C, 8'h00);
    chk1(mbusy, 1'b1, "busy");
    chk8(mdl.mem[8'h10], 8'(ref_mem[16]), "busy write");
    chk8(8'(mdl.last_k), 8'h02, "busy bytes");
    clear(1'b1, 1'b0);
    chk1(mbusy, 1'b0, "busy clear");
    run(1'b0, 1'b0, 8'hC0, 8'h10, 8'h00, 8'h00);
    busy = 1'b0;
    chk1(mbusy, 1'b1, "busy read");
    run(1'b0, 1'b0, 8'h80, 8'h00, 8'h00, 8'h00);
    chk1(mbusy, 1'b0, "busy renewed");
    $display("test busy done");
    for (int i = 0; i < 4; i++) begin
      a = 8'(xs());
      d = 8'(xs());
      run(1'b1, 1'b0, 8'h00, a, d, {DEV, 1'b0});
      ref_mem[a] = d;
      chk8(mdl.mem[a], d, "2w write");
      chk8(8'(mdl.last_k), 8'h03, "2w write bytes");
      frames(1, 1);
      run(1'b1, 1'b1, 8'h00, a, 8'h00, {DEV, 1'b0});
      chk8(rx, d, "2w read");
      frames(2, 1);
      chk1(mdl.host_ack, 1'b1, "no final ack");
      run(1'b1, 1'b0, 8'h00, 8'h00, 8'h00, {DEV, 1'b1});
      chk8(rx, 8'(ref_mem[8'(a + 1)]), "2w current read");
      frames(1, 1);
    end
    $display("test two-wire done");
    for (int n = 0; n < 3; n++) begin
      nack_at = 3'(n);
      run(1'b1, 1'b0, 8'h00, 8'h20, 8'h99, {DEV, 1'b0});
      nack_at = 3'h7;
      chk1(aerr, 1'b1, "ack error");
      chk8(8'(mdl.last_k), 8'(n + 1), "bytes before stop");
      chk8(mdl.mem[8'h20], 8'(ref_mem[32]), "refused write");
      frames(1, 1);
      run(1'b1, 1'b0, 8'h00, 8'h21, 8'h5A, {DEV, 1'b0});
      chk1(aerr, 1'b1, "error sticky");
      frames(1, 1);
      clear(1'b0, 1'b1);
      chk1(aerr, 1'b0, "error clear");
    end
    $display("test no-ack done");
    hold = 1'b1;
    repeat (4) @(posedge mclk_in);
    run(1'b1, 1'b0, 8'h00, 8'h22, 8'h11, {DEV, 1'b0});
    hold = 1'b0;
    chk1(mbusy, 1'b1, "held clock busy");
    frames(0, 0);
    $display("test held clock done");
    tally_and_finish();
  end
  initial begin
    #600000;
    errors++;
    $display("Error %0t watchdog", $time);
    tally_and_finish();
  end
endmodule
